/* File: core/synth_config_register_bank.sv */
// Write-only configuration register bank of the synthesizer
`timescale 1ns/1ps
`default_nettype none
module synth_config_register_bank
    import synth_cfg_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clk_en,
    // Serial programming pins
    input wire logic i_serial_clock,
    input wire logic i_serial_data,
    input wire logic i_latch_enable,
    // Loop status pins
    input wire logic i_ref_counter_out,
    input wire logic i_digital_lock,
    // Divider settings
    output logic [INT_W-1:0] o_int_value,
    output logic [FRACTIONAL_NUMERATOR_W-1:0] o_fractional_numerator,
    output logic [MODULUS_W-1:0] o_fractional_modulus,
    output logic [PHASE_W-1:0] o_phase_value,
    output logic o_phase_adjust,
    output logic o_prescaler_sel,
    // Reference and pump settings
    output logic [1:0] o_noise_mode,
    output logic [2:0] o_test_mux_output_sel,
    output logic o_ref_doubler,
    output logic o_reference_halver,
    output logic [REFDIV_W-1:0] o_ref_divider,
    output logic o_double_buffer,
    output logic [PUMP_W-1:0] o_pump_current,
    output logic o_lock_detect_function,
    output logic o_lock_detect_precision,
    output logic o_detector_polarity,
    output logic o_power_down,
    output logic o_pump_tristate,
    output logic o_counter_reset,
    // Band selection
    output logic o_fast_band_select,
    output logic o_band_select_busy,
    // Output stage
    output logic o_vco_power_down,
    output logic [1:0] o_output_power,
    output logic o_rf_output_on,
    output logic o_aux_output_on,
    output logic o_aux_select,
    output logic [1:0] o_aux_power
);
    // Pin synchronisers: serial clock, data, latch, reference, lock
    localparam int PIN_N = 5;
    logic [PIN_N-1:0] meta_r;
    logic [PIN_N-1:0] sync_r;
    logic [PIN_N-1:0] prev_r;
    wire [PIN_N-1:0] pins = {i_serial_clock, i_serial_data, i_latch_enable,
                             i_ref_counter_out, i_digital_lock};

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else if (i_clk_en) begin
            meta_r <= pins;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Data is aligned with the clock edge because both take the same delay
    wire sclk_rise = sync_r[4] & ~prev_r[4];
    wire sdata = sync_r[3];
    wire latch_rise = sync_r[2] & ~prev_r[2];
    wire ref_rise = sync_r[1] & ~prev_r[1];
    wire lock_s = sync_r[0];

    logic [WORD_W-1:0] word;
    logic load;

    serial_shift_in #(
        .WIDTH(WORD_W)
    ) u_shift (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_shift(sclk_rise),
        .i_bit(sdata),
        .i_latch(latch_rise),
        .o_word(word),
        .o_load(load)
    );

    // Latches; codes six and seven are ignored
    logic [WORD_W-1:0] cfg_r [LATCH_COUNT];
    wire [SEL_W-1:0] lsel = word[SEL_W-1:0];
    wire lsel_ok = lsel <= SEL_SPARE;
    wire r0_load = load && lsel == SEL_INT_FRACTIONAL_NUMERATOR;
    wire [WORD_W-1:0] w1 = cfg_r[SEL_PHASE_MOD];
    wire [WORD_W-1:0] w2 = cfg_r[SEL_REF_PUMP];
    wire [WORD_W-1:0] w4 = cfg_r[SEL_OUTPUT];

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < LATCH_COUNT; i++) begin
                cfg_r[i] <= WORD_RESET;
            end
        end else if (i_clk_en && load && lsel_ok) begin
            cfg_r[lsel] <= word;
        end
    end

    // Double-buffered copies, taken over only on a word 0 write
    logic [MODULUS_W-1:0] modulus_act_r;
    logic [PHASE_W-1:0] phase_act_r;
    logic doubler_act_r;
    logic halver_act_r;
    logic [REFDIV_W-1:0] refdiv_act_r;
    logic [PUMP_W-1:0] pump_act_r;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            modulus_act_r <= '0;
            phase_act_r <= '0;
            doubler_act_r <= 1'b0;
            halver_act_r <= 1'b0;
            refdiv_act_r <= '0;
            pump_act_r <= '0;
        end else if (i_clk_en && r0_load) begin
            modulus_act_r <= w1[MODULUS_LSB +: MODULUS_W];
            phase_act_r <= w1[PHASE_LSB +: PHASE_W];
            doubler_act_r <= w2[DOUBLER_BIT];
            halver_act_r <= w2[HALVER_BIT];
            refdiv_act_r <= w2[REFDIV_LSB +: REFDIV_W];
            pump_act_r <= w2[PUMP_LSB +: PUMP_W];
        end
    end

    assign o_fractional_modulus = modulus_act_r;
    assign o_phase_value = phase_act_r;
    assign o_ref_doubler = doubler_act_r;
    assign o_reference_halver = halver_act_r;
    assign o_ref_divider = refdiv_act_r;
    assign o_pump_current = pump_act_r;

    // Direct fields, each a bit slice of a latch
    assign o_int_value = cfg_r[SEL_INT_FRACTIONAL_NUMERATOR][INT_LSB +: INT_W];
    assign o_fractional_numerator = cfg_r[SEL_INT_FRACTIONAL_NUMERATOR][FRACTIONAL_NUMERATOR_LSB +: FRACTIONAL_NUMERATOR_W];
    assign o_phase_adjust = w1[PHASE_ADJ_BIT];
    assign o_prescaler_sel = w1[PRESCALER_BIT];
    assign o_noise_mode = w2[NOISE_LSB +: 2];
    assign o_test_mux_output_sel = w2[TMUX_LSB +: 3];
    assign o_double_buffer = w2[DBUF_BIT];
    assign o_lock_detect_function = w2[LOCK_FN_BIT];
    assign o_lock_detect_precision = w2[LOCK_PREC_BIT];
    assign o_detector_polarity = w2[POLARITY_BIT];
    assign o_power_down = w2[PDOWN_BIT];
    assign o_pump_tristate = w2[TRISTATE_BIT];
    assign o_counter_reset = w2[CNT_RESET_BIT];
    assign o_fast_band_select = cfg_r[SEL_BAND_MODE][FAST_BAND_BIT];
    assign o_vco_power_down = w4[VCO_PDOWN_BIT];
    assign o_output_power = w4[PWR_LSB +: 2];
    assign o_aux_select = w4[AUX_SEL_BIT];
    assign o_aux_power = w4[AUX_PWR_LSB +: 2];

    // Band selection start: once after reset, then on word 0 writes while phase adjust is clear
    logic boot_r;
    logic band_pulse;
    wire phase_adj = w1[PHASE_ADJ_BIT];
    wire band_start = boot_r | (r0_load & ~phase_adj);

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            boot_r <= 1'b1;
        end else if (i_clk_en) begin
            boot_r <= 1'b0;
        end
    end

    band_select_timer #(
        .DIV_W(BAND_DIV_W),
        .CYCLES(BAND_CYCLES)
    ) u_band (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_ref_tick(ref_rise),
        .i_divider(w4[BAND_DIV_LSB +: BAND_DIV_W]),
        .i_start(band_start),
        .o_busy(o_band_select_busy),
        .o_band_tick(band_pulse)
    );

    // Band clock periods counted apart from the timer, for its own check
    localparam int SEEN_W = $clog2(BAND_CYCLES + 1);
    logic [SEEN_W-1:0] band_seen_r;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            band_seen_r <= '0;
        end else if (i_clk_en) begin
            if (band_start) begin
                band_seen_r <= '0;
            end else if (band_pulse) begin
                band_seen_r <= band_seen_r + 1'b1;
            end
        end
    end

    // Output stage gating; supply held off while unlocked if muting
    wire mute_lock = w4[MUTE_LOCK_BIT];
    wire rf_on_nxt = w4[RF_EN_BIT] & (~mute_lock | lock_s);
    wire aux_on_nxt = w4[AUX_EN_BIT] & rf_on_nxt;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_rf_output_on <= 1'b0;
            o_aux_output_on <= 1'b0;
        end else if (i_clk_en) begin
            o_rf_output_on <= rf_on_nxt;
            o_aux_output_on <= aux_on_nxt;
        end
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    r0_capture_a: assert property (
        i_clk_en && r0_load |=> cfg_r[SEL_INT_FRACTIONAL_NUMERATOR] == $past(word))
        else $error("word 0 not captured on its select code");
    dbuf_hold_a: assert property (
        i_clk_en && load && lsel == SEL_PHASE_MOD |=> $stable(modulus_act_r) && $stable(phase_act_r))
        else $error("buffered setting changed without word 0 write");
    dbuf_apply_a: assert property (
        i_clk_en && r0_load |=> modulus_act_r == $past(w1[MODULUS_LSB +: MODULUS_W])
            && refdiv_act_r == $past(w2[REFDIV_LSB +: REFDIV_W]))
        else $error("buffered setting not applied on word 0 write");
    band_start_a: assert property (
        i_clk_en && r0_load && !phase_adj |=> o_band_select_busy)
        else $error("word 0 write did not start band selection");
    skip_band_a: assert property (
        i_clk_en && r0_load && phase_adj && !boot_r && !o_band_select_busy |=> !o_band_select_busy)
        else $error("band selection ran with phase adjust set");
    aux_gate_a: assert property (
        o_aux_output_on |-> o_rf_output_on)
        else $error("auxiliary output on without primary output");
    mute_lock_a: assert property (
        i_clk_en && mute_lock && !lock_s |=> !o_rf_output_on)
        else $error("output supply on before lock while muting");
    boot_band_a: assert property (
        $fell(boot_r) |-> o_band_select_busy)
        else $error("no band selection after power-up");
    int_fractional_numerator_load_a: assert property (
        i_clk_en && r0_load |=> o_int_value == $past(word[INT_LSB +: INT_W])
            && o_fractional_numerator == $past(word[FRACTIONAL_NUMERATOR_LSB +: FRACTIONAL_NUMERATOR_W]))
        else $error("integer or fraction not taken from word 0");
    phase_word_a: assert property (
        i_clk_en && load && lsel == SEL_PHASE_MOD |=> o_phase_adjust == $past(word[PHASE_ADJ_BIT])
            && o_prescaler_sel == $past(word[PRESCALER_BIT]))
        else $error("phase adjust or prescaler not taken from word 1");
    ctrl_word_a: assert property (
        i_clk_en && load && lsel == SEL_REF_PUMP |=> o_double_buffer == $past(word[DBUF_BIT])
            && o_counter_reset == $past(word[CNT_RESET_BIT]))
        else $error("control bits not taken from word 2");
    ref_hold_a: assert property (
        i_clk_en && load && lsel == SEL_REF_PUMP |=> $stable(refdiv_act_r) && $stable(pump_act_r)
            && $stable(doubler_act_r) && $stable(halver_act_r))
        else $error("reference setting changed without word 0 write");
    power_level_a: assert property (
        i_clk_en && load && lsel == SEL_OUTPUT |=> o_output_power == $past(word[PWR_LSB +: 2]))
        else $error("output power not taken from word 4");
    bad_select_a: assert property (
        i_clk_en && load && !lsel_ok |=> $stable(o_int_value) && $stable(w1) && $stable(w2)
            && $stable(w4))
        else $error("unused select code changed a latch");
    aux_down_a: assert property (
        i_clk_en && !w4[AUX_EN_BIT] |=> !o_aux_output_on)
        else $error("auxiliary stage on while not enabled");
    busy_rise_a: assert property (
        $rose(o_band_select_busy) |-> $past(band_start))
        else $error("band selection began without a start");
    band_count_a: assert property (
        i_clk_en && $fell(o_band_select_busy) && !band_start |=> band_seen_r == SEEN_W'(BAND_CYCLES))
        else $error("band selection length not ten clock periods");
    // Clock enable low must freeze every register
    clock_freeze_a: assert property (
        !i_clk_en |=> $stable(o_band_select_busy) && $stable(o_rf_output_on) && $stable(boot_r)
            && $stable(modulus_act_r) && $stable(o_int_value))
        else $error("state changed while clock enable was low");
endmodule
`default_nettype wire

/* File: core/synth_cfg_pkg.sv */
// Field layout and constants of the synthesizer configuration words
package synth_cfg_pkg;
    localparam int WORD_W = 32;
    localparam int SEL_W = 3;
    localparam int LATCH_COUNT = 6;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    // Latch select codes in the three low bits
    localparam logic [2:0] SEL_INT_FRACTIONAL_NUMERATOR = 3'h0;
    localparam logic [2:0] SEL_PHASE_MOD = 3'h1;
    localparam logic [2:0] SEL_REF_PUMP = 3'h2;
    localparam logic [2:0] SEL_BAND_MODE = 3'h3;
    localparam logic [2:0] SEL_OUTPUT = 3'h4;
    localparam logic [2:0] SEL_SPARE = 3'h5;
    // Integer and fraction word
    localparam int INT_LSB = 15;
    localparam int INT_W = 16;
    localparam int FRACTIONAL_NUMERATOR_LSB = 3;
    localparam int FRACTIONAL_NUMERATOR_W = 12;
    // Phase and modulus word
    localparam int PHASE_ADJ_BIT = 28;
    localparam int PRESCALER_BIT = 27;
    localparam int PHASE_LSB = 15;
    localparam int PHASE_W = 12;
    localparam int MODULUS_LSB = 3;
    localparam int MODULUS_W = 12;
    // Reference, pump and control word
    localparam int NOISE_LSB = 29;
    localparam int TMUX_LSB = 26;
    localparam int DOUBLER_BIT = 25;
    localparam int HALVER_BIT = 24;
    localparam int REFDIV_LSB = 14;
    localparam int REFDIV_W = 10;
    localparam int DBUF_BIT = 13;
    localparam int PUMP_LSB = 9;
    localparam int PUMP_W = 4;
    localparam int LOCK_FN_BIT = 8;
    localparam int LOCK_PREC_BIT = 7;
    localparam int POLARITY_BIT = 6;
    localparam int PDOWN_BIT = 5;
    localparam int TRISTATE_BIT = 4;
    localparam int CNT_RESET_BIT = 3;
    // Band mode word
    localparam int FAST_BAND_BIT = 23;
    // Output word
    localparam int BAND_DIV_LSB = 12;
    localparam int BAND_DIV_W = 8;
    localparam int VCO_PDOWN_BIT = 11;
    localparam int MUTE_LOCK_BIT = 10;
    localparam int AUX_SEL_BIT = 9;
    localparam int AUX_EN_BIT = 8;
    localparam int AUX_PWR_LSB = 6;
    localparam int RF_EN_BIT = 5;
    localparam int PWR_LSB = 3;
    // Band selection length in band select clock periods
    localparam int BAND_CYCLES = 10;
endpackage

/* File: core/serial_shift_in.sv */
// 32-bit serial input shift register with latch capture
`timescale 1ns/1ps
`default_nettype none
module serial_shift_in
    import synth_cfg_pkg::*;
#(
    parameter int WIDTH = WORD_W
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clk_en,
    // Serial strobes, already synchronised
    input wire logic i_shift,
    input wire logic i_bit,
    input wire logic i_latch,
    // Captured word
    output logic [WIDTH-1:0] o_word,
    output logic o_load
);
    if (WIDTH < SEL_W + 1) begin : g_chk
        $error("WIDTH too small for select code");
    end

    logic [WIDTH-1:0] shift_r;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            shift_r <= '0;
            o_word <= '0;
            o_load <= 1'b0;
        end else if (i_clk_en) begin
            if (i_shift) begin
                shift_r <= {shift_r[WIDTH-2:0], i_bit};
            end
            o_load <= i_latch;
            if (i_latch) begin
                o_word <= shift_r;
            end
        end
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    shift_order_a: assert property (
        i_clk_en && i_shift |=> shift_r == {$past(shift_r[WIDTH-2:0]), $past(i_bit)})
        else $error("serial word not shifted msb first");
endmodule
`default_nettype wire

/* File: core/band_select_timer.sv */
// Band selection timer clocked by the divided reference counter output
`timescale 1ns/1ps
`default_nettype none
module band_select_timer
    import synth_cfg_pkg::*;
#(
    parameter int DIV_W = BAND_DIV_W,
    parameter int CYCLES = BAND_CYCLES
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clk_en,
    // Reference ticks, divider and start
    input wire logic i_ref_tick,
    input wire logic [DIV_W-1:0] i_divider,
    input wire logic i_start,
    // Status
    output logic o_busy,
    output logic o_band_tick
);
    localparam int CNT_W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [CNT_W-1:0] CYC_LAST = CNT_W'(CYCLES - 1);

    if (CYCLES < 1 || DIV_W < 1) begin : g_chk
        $error("band timer parameters out of range");
    end

    logic [DIV_W-1:0] div_cnt_r;
    logic [CNT_W-1:0] cyc_cnt_r;
    // A zero divider is served as divide-by-one
    wire [DIV_W-1:0] div_last = (i_divider == '0) ? '0 : i_divider - 1'b1;
    wire div_wrap = div_cnt_r == div_last;
    wire band_tick = o_busy & i_ref_tick & div_wrap;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_busy <= 1'b0;
            o_band_tick <= 1'b0;
            div_cnt_r <= '0;
            cyc_cnt_r <= '0;
        end else if (i_clk_en) begin
            o_band_tick <= band_tick;
            if (i_start) begin
                o_busy <= 1'b1;
                div_cnt_r <= '0;
                cyc_cnt_r <= '0;
            end else if (o_busy && i_ref_tick) begin
                div_cnt_r <= div_wrap ? '0 : div_cnt_r + 1'b1;
                if (div_wrap) begin
                    cyc_cnt_r <= cyc_cnt_r + 1'b1;
                    if (cyc_cnt_r == CYC_LAST) begin
                        o_busy <= 1'b0;
                        cyc_cnt_r <= '0;
                    end
                end
            end
        end
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    end_count_a: assert property (
        $fell(o_busy) |-> $past(cyc_cnt_r) == CYC_LAST && $past(band_tick))
        else $error("band selection ended after wrong count");
    div_tick_a: assert property (
        i_clk_en && o_busy && i_ref_tick && !i_start && !div_wrap |=> !o_band_tick && div_cnt_r != '0)
        else $error("band clock ticked before divider wrapped");
endmodule
`default_nettype wire

/* File: test/synth_host_model.sv */
// Host model driving the three-wire serial programming port
`timescale 1ns/1ps
`default_nettype none
module synth_host_model (
    // Clock
    input wire logic i_clock,
    // Serial programming pins
    output logic o_serial_clock,
    output logic o_serial_data,
    output logic o_latch_enable
);
    initial begin
        o_serial_clock = 1'b0;
        o_serial_data = 1'b0;
        o_latch_enable = 1'b0;
    end

    // Each level held 4 clocks so the two-flop synchroniser sees it
    task automatic write_word(input logic [31:0] word);
        for (int i = 31; i >= 0; i--) begin
            @(negedge i_clock);
            o_serial_data = word[i];
            repeat (4) @(negedge i_clock);
            o_serial_clock = 1'b1;
            repeat (4) @(negedge i_clock);
            o_serial_clock = 1'b0;
        end
        // Released data line must not keep showing the last bit
        o_serial_data = ~word[0];
        repeat (4) @(negedge i_clock);
        o_latch_enable = 1'b1;
        repeat (4) @(negedge i_clock);
        o_latch_enable = 1'b0;
        repeat (6) @(negedge i_clock);
    endtask
endmodule
`default_nettype wire

/* File: test/synth_config_register_bank_tb.sv */
// Self-checking testbench of the synthesizer configuration register bank
`timescale 1ns/1ps
`default_nettype none
module synth_config_register_bank_tb
    import synth_cfg_pkg::*;
;
    localparam logic [31:0] INT_FRACTIONAL_NUMERATOR_WORD = {1'b0, 16'hA5C3, 12'h9E1, SEL_INT_FRACTIONAL_NUMERATOR};
    logic i_clock, i_rst, i_clk_en, i_ref_counter_out, i_digital_lock;
    logic i_serial_clock, i_serial_data, i_latch_enable;
    logic [INT_W-1:0] o_int_value;
    logic [FRACTIONAL_NUMERATOR_W-1:0] o_fractional_numerator;
    logic [MODULUS_W-1:0] o_fractional_modulus;
    logic [PHASE_W-1:0] o_phase_value;
    logic [1:0] o_noise_mode, o_output_power, o_aux_power;
    logic [2:0] o_test_mux_output_sel;
    logic [REFDIV_W-1:0] o_ref_divider;
    logic [PUMP_W-1:0] o_pump_current;
    logic o_phase_adjust, o_prescaler_sel, o_ref_doubler, o_reference_halver, o_double_buffer;
    logic o_lock_detect_function, o_lock_detect_precision, o_detector_polarity, o_power_down;
    logic o_pump_tristate, o_counter_reset, o_fast_band_select, o_band_select_busy;
    logic o_vco_power_down, o_rf_output_on, o_aux_output_on, o_aux_select;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;

    synth_config_register_bank i_synth_config_register_bank (
        .i_clock, .i_rst, .i_clk_en, .i_serial_clock, .i_serial_data, .i_latch_enable,
        .i_ref_counter_out, .i_digital_lock, .o_int_value, .o_fractional_numerator,
        .o_fractional_modulus, .o_phase_value, .o_phase_adjust, .o_prescaler_sel, .o_noise_mode,
        .o_test_mux_output_sel, .o_ref_doubler, .o_reference_halver, .o_ref_divider,
        .o_double_buffer, .o_pump_current, .o_lock_detect_function, .o_lock_detect_precision,
        .o_detector_polarity, .o_power_down, .o_pump_tristate, .o_counter_reset,
        .o_fast_band_select, .o_band_select_busy, .o_vco_power_down, .o_output_power,
        .o_rf_output_on, .o_aux_output_on, .o_aux_select, .o_aux_power
    );

    synth_host_model i_synth_host_model (
        .i_clock(i_clock),
        .o_serial_clock(i_serial_clock),
        .o_serial_data(i_serial_data),
        .o_latch_enable(i_latch_enable)
    );

    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    // Run is about 6000 cycles; ceiling leaves generous margin
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            results();
        end
    end

    task automatic results();
        if (fail_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic write(input logic [31:0] word);
        i_synth_host_model.write_word(word);
    endtask

    function automatic logic [31:0] w4(input logic [7:0] d, input logic vpd, mute, asel, aen,
                                        input logic [1:0] apwr, input logic rfen, input logic [1:0] pwr);
        return {8'h00, 4'h0, d, vpd, mute, asel, aen, apwr, rfen, pwr, SEL_OUTPUT};
    endfunction

    task automatic ref_tick();
        i_ref_counter_out = 1'b1;
        repeat (4) @(negedge i_clock);
        i_ref_counter_out = 1'b0;
        repeat (4) @(negedge i_clock);
    endtask

    // Busy must survive n-1 ticks and drop after the n-th
    task automatic run_band(input int n);
        for (int i = 0; i < n; i++) begin
            check(o_band_select_busy, 1, "busy ended early");
            ref_tick();
        end
        repeat (4) @(negedge i_clock);
        check(o_band_select_busy, 0, "busy ended late");
    endtask

    task automatic t_reset();
        check(o_int_value, 0, "int in reset");
        check(o_rf_output_on, 0, "rf in reset");
        check(o_band_select_busy, 0, "busy in reset");
        i_rst = 1'b0;
        repeat (4) @(negedge i_clock);
        run_band(10);
    endtask

    task automatic t_fields();
        write({3'h0, 1'b0, 1'b1, 12'h5A3, 12'hC3A, SEL_PHASE_MOD});
        check({o_phase_adjust, o_prescaler_sel}, 2'b01, "adjust prescaler");
        check({o_phase_value, o_fractional_modulus}, 0, "phase modulus early");
        write({1'b0, 2'h2, 3'h5, 1'b1, 1'b1, 10'h2B7, 1'b1, 4'hB, 6'h2D, SEL_REF_PUMP});
        check({o_noise_mode, o_test_mux_output_sel}, 5'h15, "noise mux");
        check(o_double_buffer, 1, "double buffer");
        check({o_lock_detect_function, o_lock_detect_precision, o_detector_polarity, o_power_down,
               o_pump_tristate, o_counter_reset}, 6'h2D, "control bits");
        check({o_ref_doubler, o_reference_halver, o_ref_divider, o_pump_current}, 0,
              "reference early");
        write({8'h00, 1'b1, 20'h00000, SEL_BAND_MODE});
        check(o_fast_band_select, 1, "fast band");
        write(INT_FRACTIONAL_NUMERATOR_WORD);
        check({o_int_value, o_fractional_numerator}, {16'hA5C3, 12'h9E1}, "int fractional_numerator");
        check({o_phase_value, o_fractional_modulus}, {12'h5A3, 12'hC3A}, "phase modulus");
        check({o_ref_doubler, o_reference_halver, o_ref_divider, o_pump_current},
              {2'b11, 10'h2B7, 4'hB}, "reference");
        run_band(10);
    endtask

    task automatic t_output();
        for (int p = 0; p < 4; p++) begin
            write(w4(8'h00, 1'b1, 1'b0, 1'b1, 1'b1, 2'(3 - p), 1'b1, 2'(p)));
            check(o_output_power, 32'(p), "power level");
            check(o_aux_power, 32'(3 - p), "aux power");
            check({o_rf_output_on, o_aux_output_on}, 2'b11, "outputs on");
            check({o_vco_power_down, o_aux_select}, 2'b11, "vco down aux select");
        end
        // Auxiliary asked for while primary is off
        write(w4(8'h00, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0, 1'b0, 2'h2));
        check({o_rf_output_on, o_aux_output_on}, 2'b00, "aux without primary");
        write(w4(8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b1, 2'h2));
        check({o_rf_output_on, o_aux_output_on, o_vco_power_down}, 3'b100, "aux down");
        write(w4(8'h00, 1'b0, 1'b1, 1'b0, 1'b1, 2'h0, 1'b1, 2'h0));
        check({o_rf_output_on, o_aux_output_on}, 2'b00, "muted unlocked");
        i_digital_lock = 1'b1;
        repeat (5) @(negedge i_clock);
        check({o_rf_output_on, o_aux_output_on}, 2'b11, "locked on");
        i_digital_lock = 1'b0;
        repeat (5) @(negedge i_clock);
        check(o_rf_output_on, 0, "lock lost");
    endtask

    task automatic t_band();
        write(w4(8'h03, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0));
        write(INT_FRACTIONAL_NUMERATOR_WORD);
        // Frozen clock must ignore this reference tick
        i_clk_en = 1'b0;
        ref_tick();
        check(o_band_select_busy, 1, "busy while frozen");
        i_clk_en = 1'b1;
        run_band(30);
    endtask

    task automatic t_phase_adjust();
        write({3'h0, 1'b1, 1'b1, 12'h5A3, 12'hC3A, SEL_PHASE_MOD});
        check(o_phase_adjust, 1, "phase adjust");
        write(INT_FRACTIONAL_NUMERATOR_WORD);
        check(o_band_select_busy, 0, "band skipped");
        ref_tick();
        ref_tick();
        check(o_band_select_busy, 0, "band still idle");
    endtask

    // Codes 6 and 7 address nothing; code 5 must not reach other latches
    task automatic t_select();
        write({1'b0, 16'h1234, 12'h567, 3'h6});
        write({1'b0, 16'h1234, 12'h567, 3'h7});
        write({1'b0, 16'h1234, 12'h567, SEL_SPARE});
        check({o_int_value, o_fractional_numerator}, {16'hA5C3, 12'h9E1}, "stray select");
        check(o_output_power, 0, "stray output");
    endtask

    initial begin
        i_rst = 1'b1;
        i_clk_en = 1'b1;
        i_ref_counter_out = 1'b0;
        i_digital_lock = 1'b0;
        repeat (12) @(negedge i_clock);
        t_reset();
        t_fields();
        t_output();
        t_band();
        t_phase_adjust();
        t_select();
        results();
    end
endmodule
`default_nettype wire
